/* File: src/cmsr_core.sv */
`timescale 1ns/10ps
module cmsr_core (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    // Instruction issue
    input  wire logic [15:0] instr_i,
    input  wire logic        instr_valid_i,
    output logic             instr_ready_o,
    // Data memory
    output logic      [11:0] mem_addr_o,
    input  wire logic [7:0]  mem_rdata_i,
    output logic      [7:0]  mem_wdata_o,
    output logic             mem_we_o,
    // Architectural state view
    output logic      [20:0] pc_o,
    output logic      [7:0]  accum_o,
    output logic      [7:0]  status_o,
    output logic      [7:0]  bank_select_reg_o,
    output logic      [7:0]  product_high_byte_o,
    output logic      [7:0]  product_low_byte_o,
    output logic      [20:0] stack_top_entry_o,
    output logic      [4:0]  stack_ptr_o,
    // Shadow and latch load
    input  wire logic        shadow_load_i,
    input  wire logic [7:0]  bank_select_load_i,
    input  wire logic        bank_select_we_i
);
    typedef enum logic [1:0] {CMSR_EXEC, CMSR_FLUSH} cmsr_phase_t;

    typedef struct packed {
        cmsr_phase_t phase;
        logic [20:0] pc;
        logic [7:0]  accum;
        logic [7:0]  status;
        logic [7:0]  bank_sel;
        logic [7:0]  prod_hi;
        logic [7:0]  prod_lo;
        logic [7:0]  accumulator_shadow;
        logic [7:0]  flags_shadow;
        logic [7:0]  bank_shadow;
        logic [4:0]  sp;
        logic [7:0]  wdata;
        logic        we;
        logic [11:0] waddr;
    } cmsr_state_t;

    cmsr_state_t st_reg;
    cmsr_state_t st_next;
    logic [20:0] stack_mem [cmsr_pkg::STACK_DEPTH];
    logic        push_en;
    logic [20:0] push_val;
    logic        is_neg;
    logic [7:0]  alu_res;
    logic [4:0]  alu_flags;
    logic [4:0]  alu_mask;
    logic [15:0] product;
    logic [7:0]  mul_opnd;
    logic [20:0] pc_plus2;
    logic [20:0] top;

    // File address from bank bit, offset and bank select
    function automatic logic [11:0] file_addr(input logic [15:0] ins, input logic [7:0] bank_sel);
        logic [3:0] bank;
        bank = bank_sel[3:0];
        if (!ins[cmsr_pkg::BANK_BIT]) begin
            bank = (ins[7:0] < cmsr_pkg::ACCESS_SPLIT) ? cmsr_pkg::ACCESS_LOW : cmsr_pkg::ACCESS_HIGH;
        end
        return {bank, ins[7:0]};
    endfunction

    // Opcode classes, shared by operand select and next-state logic
    function automatic logic dec_mul_lit(input logic [15:0] ins);
        return ins[15:8] == cmsr_pkg::OP_MUL_LIT;
    endfunction

    function automatic logic dec_mul_file(input logic [15:0] ins);
        return ins[15:9] == cmsr_pkg::OP_MUL_FILE;
    endfunction

    function automatic logic dec_neg_file(input logic [15:0] ins);
        return ins[15:9] == cmsr_pkg::OP_NEG_FILE;
    endfunction

    function automatic logic dec_rlc_file(input logic [15:0] ins);
        return ins[15:10] == cmsr_pkg::OP_RLC_FILE;
    endfunction

    function automatic logic dec_rel_call(input logic [15:0] ins);
        return ins[15:11] == cmsr_pkg::OP_REL_CALL;
    endfunction

    function automatic logic dec_ret_lit(input logic [15:0] ins);
        return ins[15:8] == cmsr_pkg::OP_RET_LIT;
    endfunction

    // Both return flavours and the literal return share one path
    function automatic logic dec_return(input logic [15:0] ins);
        return ins[15:1] == cmsr_pkg::OP_RET || ins[15:1] == cmsr_pkg::OP_RET_INT || dec_ret_lit(ins);
    endfunction

    cmsr_alu cmsr_alu_i (
        .opnd_i      (mem_rdata_i),
        .carry_i     (st_reg.status[cmsr_pkg::FLAG_C]),
        .is_neg_i    (is_neg),
        .result_o    (alu_res),
        .flags_o     (alu_flags),
        .flag_mask_o (alu_mask)
    );

    assign is_neg   = dec_neg_file(instr_i);
    assign pc_plus2 = st_reg.pc + cmsr_pkg::PC_STEP;
    assign top      = (st_reg.sp == 5'h00) ? cmsr_pkg::PC_RESET : stack_mem[st_reg.sp - 5'h01];
    assign mul_opnd = dec_mul_lit(instr_i) ? instr_i[7:0] : mem_rdata_i;
    assign product  = 16'(st_reg.accum) * 16'(mul_opnd);

    always_comb begin
        st_next  = st_reg;
        push_en  = 1'b0;
        push_val = pc_plus2;
        st_next.we = 1'b0;
        if (st_reg.phase == CMSR_FLUSH) begin
            // Second cycle of a two-cycle op does nothing
            st_next.phase = CMSR_EXEC;
        end else if (instr_valid_i) begin
            st_next.pc = pc_plus2;
            if (dec_mul_lit(instr_i) || dec_mul_file(instr_i)) begin
                st_next.prod_hi = product[15:8];
                st_next.prod_lo = product[7:0];
                // Status left alone on purpose
            end else if (is_neg || dec_rlc_file(instr_i)) begin
                st_next.status = (st_reg.status & ~{3'h0, alu_mask}) | {3'h0, alu_flags & alu_mask};
                if (!is_neg && !instr_i[cmsr_pkg::DEST_BIT]) begin
                    st_next.accum = alu_res;
                end else begin
                    st_next.we    = 1'b1;
                    st_next.wdata = alu_res;
                    st_next.waddr = file_addr(instr_i, st_reg.bank_sel);
                end
            end else if (instr_i == cmsr_pkg::OP_PUSH) begin
                push_en = 1'b1;
            end else if (instr_i == cmsr_pkg::OP_POP) begin
                if (st_reg.sp != 5'h00) begin
                    st_next.sp = st_reg.sp - 5'h01;
                end
            end else if (dec_rel_call(instr_i)) begin
                // Dead second cycle while the target is fetched
                push_en       = 1'b1;
                st_next.pc    = pc_plus2 + {{9{instr_i[10]}}, instr_i[10:0], 1'b0};
                st_next.phase = CMSR_FLUSH;
            end else if (dec_return(instr_i)) begin
                // Empty stack returns to the reset vector
                st_next.pc    = top;
                st_next.phase = CMSR_FLUSH;
                if (st_reg.sp != 5'h00) begin
                    st_next.sp = st_reg.sp - 5'h01;
                end
                if (dec_ret_lit(instr_i)) begin
                    st_next.accum = instr_i[7:0];
                end else if (instr_i[cmsr_pkg::SHADOW_BIT]) begin
                    st_next.accum    = st_reg.accumulator_shadow;
                    st_next.status   = st_reg.flags_shadow;
                    st_next.bank_sel = st_reg.bank_shadow;
                end
            end
        end
        // Stack overflow saturates; top entry is overwritten
        if (push_en && st_reg.sp != 5'(cmsr_pkg::STACK_DEPTH)) begin
            st_next.sp = st_reg.sp + 5'h01;
        end
        // Software bank load wins over a shadow restore in the same cycle
        if (bank_select_we_i) begin
            st_next.bank_sel = bank_select_load_i;
        end
        if (shadow_load_i) begin
            st_next.accumulator_shadow = st_reg.accum;
            st_next.flags_shadow       = st_reg.status;
            st_next.bank_shadow        = st_reg.bank_sel;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st_reg <= '{phase: CMSR_EXEC, pc: cmsr_pkg::PC_RESET, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Stack storage has no reset; the pointer guards it
    always_ff @(posedge core_clk_i) begin
        if (!srst_i && push_en) begin
            stack_mem[(st_reg.sp == 5'(cmsr_pkg::STACK_DEPTH)) ? st_reg.sp - 5'h01 : st_reg.sp] <= push_val;
        end
    end

    // Ready is combinational; every data output except mem_addr_o and stack_top_entry_o comes from a flip-flop
    assign instr_ready_o       = (st_reg.phase == CMSR_EXEC);
    assign mem_addr_o          = st_reg.we ? st_reg.waddr : file_addr(instr_i, st_reg.bank_sel);
    assign mem_wdata_o         = st_reg.wdata;
    assign mem_we_o            = st_reg.we;
    assign pc_o                = st_reg.pc;
    assign accum_o             = st_reg.accum;
    assign status_o            = st_reg.status;
    assign bank_select_reg_o   = st_reg.bank_sel;
    assign product_high_byte_o = st_reg.prod_hi;
    assign product_low_byte_o  = st_reg.prod_lo;
    assign stack_top_entry_o   = top;
    assign stack_ptr_o         = st_reg.sp;
endmodule

/* File: shared/cmsr_pkg.sv */
package cmsr_pkg;

    // Opcode patterns, 16-bit instruction word
    localparam logic [7:0]  OP_MUL_LIT   = 8'h0d;
    localparam logic [6:0]  OP_MUL_FILE  = 7'h01;   // 0000 001a
    localparam logic [6:0]  OP_NEG_FILE  = 7'h36;   // 0110 110a
    localparam logic [5:0]  OP_RLC_FILE  = 6'h0d;   // 0011 01da
    localparam logic [4:0]  OP_REL_CALL  = 5'h1b;   // 1101 1nnn
    localparam logic [15:0] OP_PUSH      = 16'h0005;
    localparam logic [15:0] OP_POP       = 16'h0006;
    localparam logic [14:0] OP_RET       = 15'h0009; // 0000 0000 0001 001s
    localparam logic [14:0] OP_RET_INT   = 15'h0008; // 0000 0000 0001 000s
    localparam logic [7:0]  OP_RET_LIT   = 8'h0c;

    // Field positions
    localparam int DEST_BIT   = 9;
    localparam int BANK_BIT   = 8;
    localparam int SHADOW_BIT = 0;

    // Flag positions in the status byte
    localparam int FLAG_C  = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z  = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N  = 4;

    // Sizes and reset values
    localparam int          PC_W        = 21;
    localparam int          STACK_DEPTH = 31;
    localparam int          SP_W        = 5;
    localparam logic [20:0] PC_RESET    = 21'h000000;
    localparam logic [20:0] PC_STEP     = 21'h000002;
    localparam logic [3:0]  ACCESS_LOW  = 4'h0;
    localparam logic [3:0]  ACCESS_HIGH = 4'hf;
    localparam logic [7:0]  ACCESS_SPLIT = 8'h80;

endpackage

/* File: src/cmsr_alu.sv */
`timescale 1ns/10ps
module cmsr_alu (
    // Operands
    input  wire logic [7:0]  opnd_i,
    input  wire logic        carry_i,
    input  wire logic        is_neg_i,
    // Results
    output logic      [7:0]  result_o,
    output logic      [4:0]  flags_o,
    output logic      [4:0]  flag_mask_o
);
    logic [8:0] sum;
    logic [4:0] low;

    always_comb begin
        sum         = 9'h000;
        low         = 5'h00;
        result_o    = 8'h00;
        flags_o     = 5'h00;
        flag_mask_o = 5'h00;
        if (is_neg_i) begin
            // Two's complement as ~f + 1 so carry follows the add
            sum      = {1'b0, ~opnd_i} + 9'h001;
            low      = {1'b0, ~opnd_i[3:0]} + 5'h01;
            result_o = sum[7:0];
            flags_o[cmsr_pkg::FLAG_C]  = sum[8];
            flags_o[cmsr_pkg::FLAG_DC] = low[4];
            flags_o[cmsr_pkg::FLAG_OV] = (opnd_i == 8'h80);
            flags_o[cmsr_pkg::FLAG_N]  = sum[7];
            flags_o[cmsr_pkg::FLAG_Z]  = (sum[7:0] == 8'h00);
            flag_mask_o = 5'h1f;
        end else begin
            result_o = {opnd_i[6:0], carry_i};
            flags_o[cmsr_pkg::FLAG_C] = opnd_i[7];
            flags_o[cmsr_pkg::FLAG_N] = opnd_i[6];
            flags_o[cmsr_pkg::FLAG_Z] = ({opnd_i[6:0], carry_i} == 8'h00);
            flag_mask_o = (5'h01 << cmsr_pkg::FLAG_C) | (5'h01 << cmsr_pkg::FLAG_N)
                        | (5'h01 << cmsr_pkg::FLAG_Z);
        end
    end
endmodule

/* File: sim/cmsr_core_asserts.sv */
`timescale 1ns/10ps
module cmsr_core_asserts (
    // Clock and reset
    input wire logic        core_clk_i,
    input wire logic        srst_i,
    // Watched ports
    input wire logic [15:0] instr_i,
    input wire logic        instr_valid_i,
    input wire logic        instr_ready_o,
    input wire logic [11:0] mem_addr_o,
    input wire logic [7:0]  mem_rdata_i,
    input wire logic [7:0]  mem_wdata_o,
    input wire logic        mem_we_o,
    input wire logic [20:0] pc_o,
    input wire logic [7:0]  accum_o,
    input wire logic [7:0]  status_o,
    input wire logic [7:0]  product_high_byte_o,
    input wire logic [7:0]  product_low_byte_o,
    input wire logic [20:0] stack_top_entry_o
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);
    logic [15:0] prod;
    logic [20:0] off;
    logic [7:0]  rot;
    logic        take, mll, mlf, neg, rlc, rcl, psh, rtn;
    assign prod = {product_high_byte_o, product_low_byte_o};
    assign off = {{9{instr_i[10]}}, instr_i[10:0], 1'b0};
    // Old carry enters bit 0
    assign rot = {mem_rdata_i[6:0], status_o[0]};
    assign take = instr_valid_i && instr_ready_o;
    assign mll = take && instr_i[15:8] == cmsr_pkg::OP_MUL_LIT;
    assign mlf = take && instr_i[15:9] == cmsr_pkg::OP_MUL_FILE;
    assign neg = take && instr_i[15:9] == cmsr_pkg::OP_NEG_FILE;
    assign rlc = take && instr_i[15:10] == cmsr_pkg::OP_RLC_FILE;
    assign rcl = take && instr_i[15:11] == cmsr_pkg::OP_REL_CALL;
    assign psh = take && instr_i == cmsr_pkg::OP_PUSH;
    assign rtn = take && (instr_i[15:1] == cmsr_pkg::OP_RET || instr_i[15:1] == cmsr_pkg::OP_RET_INT
        || instr_i[15:8] == cmsr_pkg::OP_RET_LIT);
    AST_MUL_LIT_PROD: assert property (mll |=> prod == $past(accum_o) * $past(instr_i[7:0]))
        else $error("literal product wrong");
    AST_MULF_PROD: assert property (mlf |=> prod == $past(accum_o) * $past(mem_rdata_i) && $stable(accum_o))
        else $error("file product wrong");
    AST_MUL_FLAGS: assert property ((mll || mlf) |=> $stable(status_o))
        else $error("multiply touched flags");
    AST_NEG_WRITE: assert property (neg |=> mem_we_o && mem_wdata_o == 8'h00 - $past(mem_rdata_i))
        else $error("negate write wrong");
    AST_ACCESS_ADDR: assert property ((mlf || neg || rlc) && !instr_i[8] && !mem_we_o |->
        mem_addr_o == {instr_i[7] ? 4'hf : 4'h0, instr_i[7:0]}) else $error("access address wrong");
    AST_RLC_ACC: assert property (rlc && !instr_i[9] |=> !mem_we_o && accum_o == $past(rot))
        else $error("rotate to accumulator wrong");
    AST_RLC_FILE: assert property (rlc && instr_i[9] |=> mem_we_o && mem_wdata_o == $past(rot))
        else $error("rotate to file wrong");
    AST_PUSH_TOP: assert property (psh |=> stack_top_entry_o == $past(pc_o) + 21'h2)
        else $error("push top wrong");
    AST_RCL_JUMP: assert property (rcl |=> !instr_ready_o && pc_o == $past(pc_o) + 21'h2 + $past(off))
        else $error("relative call wrong");
    AST_RET_PC: assert property (rtn |=> !instr_ready_o && pc_o == $past(stack_top_entry_o))
        else $error("return target wrong");
    cover property (rcl);
    cover property (neg);
    cover property (psh ##2 take);
    cover property (rtn);
endmodule
bind cmsr_core cmsr_core_asserts cmsr_core_asserts_i (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
    .instr_ready_o(instr_ready_o), .mem_addr_o(mem_addr_o), .mem_rdata_i(mem_rdata_i),
    .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .pc_o(pc_o), .accum_o(accum_o), .status_o(status_o),
    .product_high_byte_o(product_high_byte_o), .product_low_byte_o(product_low_byte_o),
    .stack_top_entry_o(stack_top_entry_o));

/* File: sim/cmsr_core_tb_top.sv */
`timescale 1ns/10ps
module cmsr_core_tb_top;
    localparam logic [15:0] FIX [10] = '{16'h0d00, 16'h0200, 16'h6c00, 16'h3400, 16'h0005, 16'h0006, 16'hd800,
        16'h0012, 16'h0010, 16'h0c00};
    localparam logic [15:0] KEEP [10] = '{16'h00ff, 16'h01ff, 16'h01ff, 16'h03ff, 16'h0000, 16'h0000, 16'h07ff,
        16'h0001, 16'h0001, 16'h00ff};
    localparam logic [15:0] CORNER [13] = '{16'h6c00, 16'h6c80, 16'h3401, 16'h0dff, 16'hdc00, 16'hdbff,
        16'h0005, 16'h0006, 16'h0006, 16'h0006, 16'h0013, 16'hd801, 16'h0c5a};
    logic        core_clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        instr_valid_i = 1'b0;
    logic        bank_select_we_i = 1'b0;
    logic        shadow_load_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic [7:0]  bank_select_load_i = 8'h00;
    logic        instr_ready_o, mem_we_o;
    logic [7:0]  mem [0:4095];
    logic [11:0] mem_addr_o, ad;
    logic [7:0]  mem_wdata_o, accum_o, status_o, bank_o, ph_o, pl_o;
    logic [20:0] pc_o, top_o, e_pc;
    logic [20:0] stk [0:31];
    logic [4:0]  sp_o, e_sp;
    logic [7:0]  e_acc, e_st, e_bank, e_ws, e_ss, e_bs, v, r, t;
    logic [15:0] e_prod;
    integer      seed = 32'h20b917fc;
    integer      error_cnt = 0;
    integer      n_tests = 0;
    integer      k, q;
    cmsr_core cmsr_core_i (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
        .instr_ready_o(instr_ready_o), .mem_addr_o(mem_addr_o), .mem_rdata_i(mem[mem_addr_o]),
        .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .pc_o(pc_o), .accum_o(accum_o), .status_o(status_o),
        .bank_select_reg_o(bank_o), .product_high_byte_o(ph_o), .product_low_byte_o(pl_o),
        .stack_top_entry_o(top_o), .stack_ptr_o(sp_o), .shadow_load_i(shadow_load_i),
        .bank_select_load_i(bank_select_load_i), .bank_select_we_i(bank_select_we_i));
    always #12.5 core_clk_i = ~core_clk_i;
    // File memory lands writes only at the edge, as the core expects
    always @(posedge core_clk_i) begin
        if (mem_we_o === 1'b1) mem[mem_addr_o] <= mem_wdata_o;
    end
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [11:0] fadr(input logic [15:0] i);
        if (i[8]) return {e_bank[3:0], i[7:0]};
        return {i[7] ? 4'hf : 4'h0, i[7:0]};
    endfunction
    // Full stack overwrites its top entry
    task automatic spush(input logic [20:0] x);
        if (e_sp < 5'd31) e_sp++;
        stk[e_sp - 5'd1] = x;
    endtask
    task automatic run(input logic [15:0] i);
        k = 0;
        while (instr_ready_o !== 1'b1) begin
            @(negedge core_clk_i);
            k++;
            if (k > 8) begin
                error_cnt++;
                summarize();
            end
        end
        ad = fadr(i);
        v = mem[ad];
        r = v;
        e_pc = e_pc + 21'h2;
        casez (i)
            16'b0000_1101_????_????: e_prod = e_acc * i[7:0];
            16'b0000_001?_????_????: e_prod = e_acc * v;
            16'b0110_110?_????_????: begin
                r = 8'h00 - v;
                e_st[4:0] = {r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0, v == 8'h00};
            end
            16'b0011_01??_????_????: begin
                t = {v[6:0], e_st[0]};
                e_st[4:0] = {t[7], e_st[3], t == 8'h00, e_st[1], v[7]};
                if (i[9]) r = t;
                else e_acc = t;
            end
            16'b0000_0000_0001_00??, 16'b0000_1100_????_????: begin
                e_pc = e_sp == 5'd0 ? 21'h0 : stk[e_sp - 5'd1];
                if (e_sp != 5'd0) e_sp--;
                if (i[11]) e_acc = i[7:0];
                else if (i[0]) {e_acc, e_st, e_bank} = {e_ws, e_ss, e_bs};
            end
            16'h0005: spush(e_pc);
            16'h0006: if (e_sp != 5'd0) e_sp--;
            default: begin
                spush(e_pc);
                e_pc = e_pc + {{9{i[10]}}, i[10:0], 1'b0};
            end
        endcase
        instr_i = i;
        instr_valid_i = 1'b1;
        @(negedge core_clk_i);
        instr_valid_i = 1'b0;
        @(negedge core_clk_i);
        chk(pc_o, e_pc);
        chk(21'(accum_o), 21'(e_acc));
        chk(21'(status_o), 21'(e_st));
        chk(21'({ph_o, pl_o}), 21'(e_prod));
        chk(21'(mem[ad]), 21'(r));
        chk(21'(bank_o), 21'(e_bank));
        chk(top_o, e_sp == 5'd0 ? 21'h0 : stk[e_sp - 5'd1]);
        chk(21'(sp_o), 21'(e_sp));
    endtask
    initial begin
        for (k = 0; k < 4096; k++) mem[k] = 8'($random(seed));
        mem[12'h000] = 8'h80;
        mem[12'h001] = 8'hff;
        mem[12'hf80] = 8'h00;
        {e_pc, e_acc, e_st, e_bank, e_ws, e_ss, e_bs, e_prod, e_sp} = '0;
        repeat (10) @(negedge core_clk_i);
        srst_i = 1'b0;
        for (q = 0; q < 13; q++) run(CORNER[q]);
        $display("corner test done");
        repeat (300) begin
            e_bank = 8'($random(seed));
            bank_select_load_i = e_bank;
            bank_select_we_i = 1'b1;
            @(negedge core_clk_i);
            bank_select_we_i = 1'b0;
            // Shadow copy a cycle after the bank load, so it holds the new bank
            shadow_load_i = 1'($random(seed));
            if (shadow_load_i) {e_ws, e_ss, e_bs} = {e_acc, e_st, e_bank};
            @(negedge core_clk_i);
            shadow_load_i = 1'b0;
            q = {$random(seed)} % 10;
            run((16'($random(seed)) & KEEP[q]) | FIX[q]);
        end
        $display("random test done");
        summarize();
    end
endmodule
